// file: logic/scr_regs.sv
// serializer config bank: two-wire slave, registers, path settings
`timescale 1ns/100ps
`default_nettype none
`include "scr_params.svh"

module scr_regs #(
    parameter logic [6:0] SLAVE_ADDR = `SCR_SLAVE_ADDR
) (
    // system clock and synchronous reset
    input wire logic clock,
    input wire logic rst,
    // serial path clock
    input wire logic link_clock,
    // two-wire management pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // auxiliary pins
    input wire logic [2:0] aux_pin_in,
    output logic [2:0] aux_pin_out,
    // configuration pins
    input wire logic [1:0] emphasis_pins,
    input wire logic far_end_detect_n_pin,
    input wire logic balance_encoder_n_pin,
    // settings in the link clock domain
    output scr_pkg::scr_path_t link_path
);

    // ******************************
    // pin synchronisers
    // ******************************
    logic [1:0] bus_s;
    logic [2:0] aux_s;
    logic [3:0] cfg_s;
    logic scl_s, sda_s, scl_d, sda_d;

    // carried inverted so the reset value matches the idle-high bus
    scr_sync #(.WIDTH(2)) u_bus_sync (
        .clock(clock),
        .rst(rst),
        .d({~scl_in, ~sda_in}),
        .q(bus_s)
    );
    scr_sync #(.WIDTH(3)) u_aux_sync (
        .clock(clock),
        .rst(rst),
        .d(aux_pin_in),
        .q(aux_s)
    );
    scr_sync #(.WIDTH(4)) u_cfg_sync (
        .clock(clock),
        .rst(rst),
        .d({far_end_detect_n_pin, balance_encoder_n_pin, emphasis_pins}),
        .q(cfg_s)
    );

    assign scl_s = ~bus_s[1];
    assign sda_s = ~bus_s[0];

    always_ff @(posedge clock) begin
        if (rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
    assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

    // ******************************
    // register storage and read mux
    // ******************************
    logic [7:0] pin_in, pin_out, emph, path, unlock, dly;
    logic [7:0] next_pin_in, next_pin_out, next_emph, next_path;
    logic [7:0] next_unlock, next_dly, rd_data, path_wmask;
    logic [7:0] ptr, wr_data;
    logic wr_stb;

    always_comb begin
        case (ptr)
            `SCR_ADDR_PIN_IN: rd_data = pin_in;
            `SCR_ADDR_PIN_OUT: rd_data = pin_out;
            `SCR_ADDR_EMPH: rd_data = emph;
            `SCR_ADDR_PATH: rd_data = path;
            `SCR_ADDR_UNLOCK: rd_data = unlock;
            `SCR_ADDR_CLK_DLY: rd_data = dly;
            default: rd_data = `SCR_RESET_VALUE;
        endcase
    end

    // ******************************
    // two-wire slave
    // ******************************
    scr_pkg::scr_state_t state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift, next_ptr, next_wr_data;
    logic is_read, next_is_read, next_sda_oe, next_wr_stb, next_sda_out;

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_ptr = ptr;
        next_wr_data = wr_data;
        next_is_read = is_read;
        next_sda_oe = sda_oe;
        next_wr_stb = 1'b0;
        // open drain: only ever pulls low
        next_sda_out = 1'b0;
        if (bus_stop) begin
            next_state = scr_pkg::ST_IDLE;
            next_sda_oe = 1'b0;
        end else if (bus_start) begin
            next_state = scr_pkg::ST_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                scr_pkg::ST_IDLE: begin
                end
                scr_pkg::ST_ADDR, scr_pkg::ST_CMD, scr_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        next_shift = {shift[6:0], sda_s};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == `SCR_BYTE_BITS) begin
                        next_sda_oe = 1'b1;
                        if (state == scr_pkg::ST_ADDR) begin
                            next_is_read = shift[0];
                            next_state = scr_pkg::ST_ADDR_ACK;
                            if (shift[7:1] != SLAVE_ADDR) begin
                                next_sda_oe = 1'b0;
                                next_state = scr_pkg::ST_IDLE;
                            end
                        end else if (state == scr_pkg::ST_CMD) begin
                            next_ptr = shift;
                            next_state = scr_pkg::ST_CMD_ACK;
                        end else begin
                            next_wr_data = shift;
                            next_wr_stb = 1'b1;
                            next_state = scr_pkg::ST_WDATA_ACK;
                        end
                    end
                end
                scr_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_bit_cnt = 4'h0;
                        if (is_read) begin
                            next_shift = rd_data;
                            next_sda_oe = ~rd_data[7];
                            next_state = scr_pkg::ST_RDATA;
                        end else begin
                            next_sda_oe = 1'b0;
                            next_state = scr_pkg::ST_CMD;
                        end
                    end
                end
                scr_pkg::ST_CMD_ACK, scr_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        next_bit_cnt = 4'h0;
                        next_sda_oe = 1'b0;
                        next_state = scr_pkg::ST_WDATA;
                    end
                end
                scr_pkg::ST_RDATA: begin
                    if (scl_rise) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt == `SCR_BYTE_BITS) begin
                            next_sda_oe = 1'b0;
                            next_state = scr_pkg::ST_RDATA_ACK;
                        end else begin
                            next_shift = {shift[6:0], 1'b0};
                            next_sda_oe = ~shift[6];
                        end
                    end
                end
                scr_pkg::ST_RDATA_ACK: begin
                    // a not-acknowledge ends the read; wait for stop
                    if (scl_rise && sda_s) begin
                        next_state = scr_pkg::ST_IDLE;
                    end else if (scl_fall) begin
                        next_bit_cnt = 4'h0;
                        next_shift = rd_data;
                        next_sda_oe = ~rd_data[7];
                        next_state = scr_pkg::ST_RDATA;
                    end
                end
                default: begin
                    next_state = scr_pkg::ST_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= scr_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            ptr <= 8'h00;
            wr_data <= 8'h00;
            is_read <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            wr_stb <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            ptr <= next_ptr;
            wr_data <= next_wr_data;
            is_read <= next_is_read;
            sda_oe <= next_sda_oe;
            sda_out <= next_sda_out;
            wr_stb <= next_wr_stb;
        end
    end

    // ******************************
    // register writes
    // ******************************
    // locked path bits keep their value when written
    assign path_wmask = {unlock[`SCR_UNL_NRZI], 1'b1, 1'b0,
                         unlock[`SCR_UNL_SCRAMBLE],
                         unlock[`SCR_UNL_BAL_BYPASS],
                         unlock[`SCR_UNL_TRAIN],
                         unlock[`SCR_UNL_PINS],
                         unlock[`SCR_UNL_PINS]};

    always_comb begin
        next_pin_in = {5'h00, aux_s};
        next_pin_out = pin_out;
        next_emph = emph;
        next_path = path;
        next_unlock = unlock;
        next_dly = dly;
        // on a write only the addressed register changes; pin_in reloads from the pins every cycle
        if (wr_stb) begin
            case (ptr)
                `SCR_ADDR_PIN_OUT: next_pin_out = wr_data & `SCR_PIN_MASK;
                `SCR_ADDR_EMPH: next_emph = wr_data & `SCR_EMPH_MASK;
                `SCR_ADDR_PATH: next_path = (path & ~path_wmask) |
                    (wr_data & path_wmask & `SCR_PATH_MASK);
                `SCR_ADDR_UNLOCK: next_unlock = wr_data & `SCR_UNLOCK_MASK;
                `SCR_ADDR_CLK_DLY: next_dly = wr_data & `SCR_DLY_MASK;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pin_in <= `SCR_RESET_VALUE;
            pin_out <= `SCR_RESET_VALUE;
            emph <= `SCR_RESET_VALUE;
            path <= `SCR_RESET_VALUE;
            unlock <= `SCR_RESET_VALUE;
            dly <= `SCR_RESET_VALUE;
        end else begin
            pin_in <= next_pin_in;
            pin_out <= next_pin_out;
            emph <= next_emph;
            path <= next_path;
            unlock <= next_unlock;
            dly <= next_dly;
        end
    end

    assign aux_pin_out = pin_out[2:0];

    // ******************************
    // effective path settings
    // ******************************
    scr_pkg::scr_path_t eff, next_eff;

    always_comb begin
        next_eff.nrzi = path[`SCR_PATH_NRZI] & unlock[`SCR_UNL_NRZI];
        next_eff.word_valid_off = path[`SCR_PATH_DV_OFF];
        next_eff.scramble = path[`SCR_PATH_SCRAMBLE];
        next_eff.bal_bypass = path[`SCR_PATH_BAL_BYPASS];
        next_eff.training = path[`SCR_PATH_TRAIN];
        next_eff.far_end_detect_n = unlock[`SCR_UNL_PINS] ?
            path[`SCR_PATH_FAR_END_N] : cfg_s[3];
        next_eff.balance_encoder_n = unlock[`SCR_UNL_PINS] ?
            path[`SCR_PATH_BAL_N] : cfg_s[2];
        next_eff.emphasis = emph[`SCR_EMPH_SEL] ?
            emph[1:0] : cfg_s[1:0];
        next_eff.clk_delay_bypass = dly[`SCR_DLY_BYPASS];
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            eff <= '0;
        end else begin
            eff <= next_eff;
        end
    end

    // ******************************
    // crossing into the link domain
    // ******************************
    // settings are quasi-static; a word may tear for one link cycle
    logic link_rst;

    scr_sync #(.WIDTH(1)) u_rst_sync (
        .clock(link_clock),
        .rst(1'b0),
        .d(rst),
        .q(link_rst)
    );
    scr_sync #(.WIDTH($bits(scr_pkg::scr_path_t))) u_path_sync (
        .clock(link_clock),
        .rst(link_rst),
        .d(eff),
        .q(link_path)
    );

    // ******************************
    // assertions
    // ******************************
    sequence s_wr(logic [7:0] a);
        wr_stb && ptr == a;
    endsequence

    property p_pin_in;
        @(posedge clock) disable iff (rst)
        !$past(rst, 1) && !$past(rst, 2) && !$past(rst, 3) |->
            pin_in == {5'h00, $past(aux_pin_in, 3)};
    endproperty
    a_pin_in: assert property (p_pin_in) else $error("pin readback wrong");

    property p_out_write;
        @(posedge clock) disable iff (rst)
        s_wr(`SCR_ADDR_PIN_OUT) |=>
            aux_pin_out == $past(wr_data[2:0]) && pin_out[7:3] == 5'h00;
    endproperty
    a_out_write: assert property (p_out_write) else $error("aux out wrong");

    property p_emph;
        @(posedge clock) disable iff (rst)
        emph[`SCR_EMPH_SEL] |=> eff.emphasis == $past(emph[1:0]);
    endproperty
    a_emph: assert property (p_emph) else $error("emphasis not from reg");

    property p_nrzi;
        @(posedge clock) disable iff (rst)
        !unlock[`SCR_UNL_NRZI] |=> !eff.nrzi;
    endproperty
    a_nrzi: assert property (p_nrzi) else $error("nrzi while locked");

    property p_dv;
        @(posedge clock) disable iff (rst)
        s_wr(`SCR_ADDR_PATH) |=> path[`SCR_PATH_DV_OFF] == $past(wr_data[6])
            ##1 eff.word_valid_off == $past(path[`SCR_PATH_DV_OFF]);
    endproperty
    a_dv: assert property (p_dv) else $error("word valid off wrong");

    property p_locked;
        @(posedge clock) disable iff (rst)
        s_wr(`SCR_ADDR_PATH) |=>
            (unlock[`SCR_UNL_SCRAMBLE] || $stable(path[4])) &&
            (unlock[`SCR_UNL_BAL_BYPASS] || $stable(path[3])) &&
            (unlock[`SCR_UNL_TRAIN] || $stable(path[2]));
    endproperty
    a_locked: assert property (p_locked) else $error("locked bit written");

    property p_pins_follow;
        @(posedge clock) disable iff (rst)
        !unlock[`SCR_UNL_PINS] |=>
            eff.far_end_detect_n == $past(cfg_s[3]) &&
            eff.balance_encoder_n == $past(cfg_s[2]);
    endproperty
    a_pins_follow: assert property (p_pins_follow) else $error("pins ignored");

    property p_dly;
        @(posedge clock) disable iff (rst)
        s_wr(`SCR_ADDR_CLK_DLY) |=> dly == ($past(wr_data) & `SCR_DLY_MASK)
            ##1 eff.clk_delay_bypass == $past(dly[7]);
    endproperty
    a_dly: assert property (p_dly) else $error("delay bypass wrong");

    property p_rsvd;
        @(posedge clock) disable iff (rst)
        wr_stb && ((ptr >= `SCR_ADDR_RSVD_LO && ptr <= `SCR_ADDR_RSVD_HI) ||
            ptr == `SCR_ADDR_RSVD_SLOT) |=> $stable(pin_out) && $stable(emph)
            && $stable(path) && $stable(unlock) && $stable(dly);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved write took");

    property p_rsvd_bits;
        @(posedge clock) disable iff (rst)
        wr_stb |=> (path[5] == 1'b0) && (emph[7:3] == 5'h00) &&
            (unlock[7:5] == 3'h0) && (dly[6:0] == 7'h00);
    endproperty
    a_rsvd_bits: assert property (p_rsvd_bits) else $error("reserved bit set");

endmodule // scr_regs

`default_nettype wire

// file: logic/scr_params.svh
// register map, field positions and masks of the serializer config bank
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH

// register offsets
`define SCR_ADDR_PIN_IN 8'h05
`define SCR_ADDR_PIN_OUT 8'h06
`define SCR_ADDR_RSVD_LO 8'h07
`define SCR_ADDR_RSVD_HI 8'h1f
`define SCR_ADDR_EMPH 8'h20
`define SCR_ADDR_PATH 8'h21
`define SCR_ADDR_UNLOCK 8'h22
`define SCR_ADDR_RSVD_SLOT 8'h23
`define SCR_ADDR_CLK_DLY 8'h24

// reset value of every listed register, and of unmapped reads
`define SCR_RESET_VALUE 8'h00

// default two-wire slave address
`define SCR_SLAVE_ADDR 7'h57

// implemented bits of each register
`define SCR_PIN_MASK 8'h07
`define SCR_EMPH_MASK 8'h07
`define SCR_PATH_MASK 8'hdf
`define SCR_UNLOCK_MASK 8'h1f
`define SCR_DLY_MASK 8'h80

// field positions
`define SCR_EMPH_SEL 2
`define SCR_PATH_NRZI 7
`define SCR_PATH_DV_OFF 6
`define SCR_PATH_SCRAMBLE 4
`define SCR_PATH_BAL_BYPASS 3
`define SCR_PATH_TRAIN 2
`define SCR_PATH_FAR_END_N 1
`define SCR_PATH_BAL_N 0
`define SCR_UNL_NRZI 4
`define SCR_UNL_SCRAMBLE 3
`define SCR_UNL_BAL_BYPASS 2
`define SCR_UNL_TRAIN 1
`define SCR_UNL_PINS 0
`define SCR_DLY_BYPASS 7

// bits in one two-wire byte
`define SCR_BYTE_BITS 4'h8

`endif

// file: logic/scr_pkg.sv
// types shared by the serializer config bank
package scr_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } scr_state_t;

    // settings that steer the serial path, as seen at the link
    typedef struct packed {
        logic nrzi;
        logic word_valid_off;
        logic scramble;
        logic bal_bypass;
        logic training;
        logic far_end_detect_n;
        logic balance_encoder_n;
        logic [1:0] emphasis;
        logic clk_delay_bypass;
    } scr_path_t;

endpackage

// file: logic/scr_sync.sv
// two-flop level synchroniser, parameterised width
`timescale 1ns/100ps
`default_nettype none

module scr_sync #(
    parameter int WIDTH = 1
) (
    // clock and synchronous reset of the receiving domain
    input wire logic clock,
    input wire logic rst,
    // level from another domain, and its synchronised copy
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clock) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule // scr_sync

`default_nettype wire

// file: verif/scr_host.sv
// two-wire management host model for the serializer config bank
`timescale 1ns/100ps
`default_nettype none

module scr_host (
    // pacing clock and resolved data line
    input wire logic clock,
    input wire logic sda,
    // clock line and data pull-down of the host
    output logic scl,
    output logic sda_pull
);
    // ****************
    // bit timing
    // ****************
    // data moves mid-way through scl low, never beside an scl edge
    localparam int HALF = 20;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic pace(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic put_bit(input logic b, output logic seen);
        pace(HALF / 2);
        sda_pull = ~b;
        pace(HALF / 2);
        scl = 1'b1;
        pace(HALF);
        seen = sda;
        scl = 1'b0;
    endtask

    // ****************
    // framing
    // ****************
    // also serves as repeated start, entered with scl low
    task automatic start();
        pace(HALF / 2);
        sda_pull = 1'b0;
        pace(HALF / 2);
        scl = 1'b1;
        pace(HALF);
        sda_pull = 1'b1;
        pace(HALF);
        scl = 1'b0;
    endtask

    task automatic stop();
        pace(HALF / 2);
        sda_pull = 1'b1;
        pace(HALF / 2);
        scl = 1'b1;
        pace(HALF);
        sda_pull = 1'b0;
        pace(HALF);
    endtask

    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(v[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask

    // last byte gets a no-ack so the slave lets go of the line
    task automatic get_byte(input logic last, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            v[i] = s;
        end
        put_bit(last, s);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] off,
                      input logic [7:0] d, output logic ok);
        logic a0;
        logic a1;
        logic a2;
        start();
        put_byte({a, 1'b0}, a0);
        put_byte(off, a1);
        put_byte(d, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] off,
                      output logic [7:0] d, output logic ok);
        logic a0;
        logic a1;
        logic a2;
        start();
        put_byte({a, 1'b0}, a0);
        put_byte(off, a1);
        start();
        put_byte({a, 1'b1}, a2);
        get_byte(1'b1, d);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule // scr_host

`default_nettype wire

// file: verif/scr_regs_tb_top.sv
// self-checking bench for the serializer config bank
`timescale 1ns/100ps
`default_nettype none
`include "scr_params.svh"

module scr_regs_tb_top;
    // ****************
    // harness
    // ****************
    localparam logic [6:0] ADDR = `SCR_SLAVE_ADDR;
    typedef struct packed {
        logic [7:0] off;
        logic [7:0] wdata;
        logic [7:0] rdata;
    } scr_row_t;
    localparam scr_row_t ROWS [9] = '{
        {`SCR_ADDR_PIN_IN, 8'hff, 8'h00},
        {`SCR_ADDR_PIN_OUT, 8'hff, 8'h07},
        {`SCR_ADDR_PIN_OUT, 8'h05, 8'h05},
        {`SCR_ADDR_EMPH, 8'hff, 8'h07},
        {`SCR_ADDR_CLK_DLY, 8'hff, 8'h80},
        {`SCR_ADDR_UNLOCK, 8'hff, 8'h1f},
        {`SCR_ADDR_PATH, 8'hff, 8'hdf},
        {8'h10, 8'h55, 8'h00},
        {`SCR_ADDR_RSVD_SLOT, 8'haa, 8'h00}
    };
    localparam logic [7:0] RW_OFFS [5] = '{`SCR_ADDR_PIN_OUT,
        `SCR_ADDR_EMPH, `SCR_ADDR_PATH, `SCR_ADDR_UNLOCK, `SCR_ADDR_CLK_DLY};

    logic clock;
    logic link_clock;
    logic rst;
    logic scl;
    logic host_pull;
    logic sda_oe;
    logic sda_out;
    logic [2:0] aux_in;
    logic [2:0] aux_out;
    logic [1:0] emph_pins;
    logic far_n_pin;
    logic bal_n_pin;
    logic ok;
    scr_pkg::scr_path_t link_path;
    wire logic sda_line;
    int miscompares;
    int n_compared;

    // pull-up on the data line; either party may pull it low
    assign sda_line = ~(host_pull | (sda_oe & ~sda_out));

    initial clock = 1'b0;
    always #5 clock = ~clock;
    initial begin
        link_clock = 1'b0;
        #3;
        forever #40 link_clock = ~link_clock;
    end

    scr_regs #(.SLAVE_ADDR(ADDR)) i_dut (
        .clock(clock), .rst(rst), .link_clock(link_clock),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .aux_pin_in(aux_in), .aux_pin_out(aux_out),
        .emphasis_pins(emph_pins), .far_end_detect_n_pin(far_n_pin),
        .balance_encoder_n_pin(bal_n_pin), .link_path(link_path)
    );

    scr_host i_host (
        .clock(clock), .sda(sda_line), .scl(scl), .sda_pull(host_pull)
    );

    // ****************
    // helpers
    // ****************
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        logic a;
        i_host.wr(ADDR, off, d, a);
    endtask

    // ack folded into bit 8, so a silent slave never passes
    task automatic rd_chk(input logic [7:0] off, input logic [7:0] e);
        logic [7:0] d;
        logic a;
        i_host.rd(ADDR, off, d, a);
        check({1'b0, a, d}, {2'b01, e});
    endtask

    // the link copy lags by two clocks plus two link edges
    task automatic settle();
        repeat (64) @(negedge clock);
    endtask

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (n_compared > 0 && miscompares == 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************
    // sequence
    // ****************
    initial begin
        rst = 1'b1;
        aux_in = 3'h0;
        emph_pins = 2'h2;
        far_n_pin = 1'b1;
        bal_n_pin = 1'b0;
        miscompares = 0;
        n_compared = 0;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        repeat (8) @(negedge clock);
        for (int r = 0; r < 9; r++) begin
            wr(ROWS[r].off, ROWS[r].wdata);
            rd_chk(ROWS[r].off, ROWS[r].rdata);
        end
        settle();
        check(link_path, 10'h3ff);
        check({7'h00, aux_out}, {7'h00, 3'h5});
        for (int l = 0; l < 4; l++) begin
            wr(`SCR_ADDR_EMPH, {6'h01, l[1:0]});
            settle();
            check({8'h00, link_path.emphasis}, {8'h00, l[1:0]});
        end
        rst = 1'b1;
        repeat (32) @(negedge clock);
        check(link_path, 10'h000);
        check({7'h00, aux_out}, 10'h000);
        rst = 1'b0;
        repeat (8) @(negedge clock);
        for (int i = 0; i < 5; i++) begin
            rd_chk(RW_OFFS[i], `SCR_RESET_VALUE);
        end
        check(link_path, 10'h014);
        // locked bits must shrug off a full write
        wr(`SCR_ADDR_PATH, 8'hff);
        rd_chk(`SCR_ADDR_PATH, 8'h40);
        settle();
        check(link_path, 10'h114);
        wr(`SCR_ADDR_UNLOCK, 8'h10);
        wr(`SCR_ADDR_PATH, 8'h80);
        rd_chk(`SCR_ADDR_PATH, 8'h80);
        settle();
        check(link_path, 10'h214);
        wr(`SCR_ADDR_UNLOCK, 8'h00);
        settle();
        check(link_path, 10'h014);
        wr(`SCR_ADDR_UNLOCK, 8'h01);
        wr(`SCR_ADDR_PATH, 8'h01);
        settle();
        check(link_path, 10'h00c);
        i_host.wr(7'h56, `SCR_ADDR_PATH, 8'hff, ok);
        check({9'h000, ok}, 10'h000);
        rd_chk(`SCR_ADDR_PATH, 8'h81);
        aux_in = 3'h5;
        repeat (8) @(negedge clock);
        rd_chk(`SCR_ADDR_PIN_IN, 8'h05);
        aux_in = 3'h2;
        repeat (8) @(negedge clock);
        rd_chk(`SCR_ADDR_PIN_IN, 8'h02);
        give_verdict();
    end

    initial begin
        repeat (80000) @(negedge clock);
        miscompares++;
        $display("BAD at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule // scr_regs_tb_top

`default_nettype wire
